// *** design/chroma_mode_delay_control_regs.sv ***
// Purpose: Three byte registers steering chroma gain, offsets, bandwidth, polarity and delays.
// Assumes: The serial bus front end supplies one-cycle write and read strobes with a subaddress.
// Notes: The host alone decides when manual gain is needed, such as for SECAM sources.
`timescale 1ns/1ps
module chroma_mode_delay_control_regs (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] sub_addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_hit,
	input wire logic [6:0] auto_gain_value,
	input wire logic color_detected,
	input wire logic hsync_in,
	input wire logic realtime_src_a,
	input wire logic realtime_src_b,
	output logic chroma_gain_manual_sel,
	output logic [6:0] chroma_gain_value,
	output logic [5:0] chroma_gain_eighths,
	output logic [1:0] blue_diff_fine_offset,
	output logic [1:0] red_diff_fine_offset,
	output logic [1:0] blue_offset_quarters,
	output logic [1:0] red_offset_quarters,
	output logic chroma_band_wide,
	output logic [2:0] luma_chroma_band_balance,
	output logic color_enable,
	output logic horiz_sync_out,
	output logic realtime_out_a,
	output logic realtime_out_b,
	output logic signed [3:0] luma_delay_llc2,
	output logic signed [4:0] luma_delay_llc
);
	import chroma_mode_pkg::*;

	typedef struct packed {
		logic [7:0] gain_reg;
		logic [7:0] offbw_reg;
		logic [7:0] mode_reg;
		logic [7:0] rd_data;
		logic rd_valid;
		logic rd_hit;
		logic [6:0] gain_code;
		logic [5:0] gain_eighths;
		logic [1:0] hs_sync1;
		logic [1:0] hs_sync2;
		logic [6:0] hs_pipe;
		logic hs_out;
		logic rta;
		logic rtb;
		logic col_sync1;
		logic col_sync2;
		logic color_en;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [5:0] mapped_gain;
	logic [7:0] hs_taps;

	// Signed 3-bit step count sign-extended to four bits.
	function automatic logic signed [3:0] sext3(input logic [2:0] v);
		sext3 = signed'({v[2], v});
	endfunction

	chroma_gain_map u_gain_map (
		.code(st_next.gain_code),
		.gain_eighths(mapped_gain)
	);

	always_comb begin
		st_next = st_reg;
		st_next.rd_valid = 1'b0;
		// Writes replace a whole register; apart from reset, no other event touches it.
		if (wr_en) begin
			case (sub_addr)
				CHROMA_GAIN_CTRL_ADDR: st_next.gain_reg = wr_data;
				CHROMA_OFFSET_BANDWIDTH_ADDR: st_next.offbw_reg = wr_data;
				MODE_DELAY_CTRL_ADDR: st_next.mode_reg = wr_data;
				default: st_next.gain_reg = st_reg.gain_reg;
			endcase
		end
		if (rd_en) begin
			st_next.rd_valid = 1'b1;
			st_next.rd_hit = 1'b1;
			case (sub_addr)
				CHROMA_GAIN_CTRL_ADDR: st_next.rd_data = st_reg.gain_reg;
				CHROMA_OFFSET_BANDWIDTH_ADDR: st_next.rd_data = st_reg.offbw_reg;
				MODE_DELAY_CTRL_ADDR: st_next.rd_data = st_reg.mode_reg;
				default: begin
					st_next.rd_data = 8'h00;
					st_next.rd_hit = 1'b0;
				end
			endcase
		end
		// Automatic gain follows the regulator; manual gain takes the code.
		if (st_reg.gain_reg[GAIN_MANUAL_BIT]) begin
			st_next.gain_code = st_reg.gain_reg[GAIN_VALUE_LSB +: 7];
		end else begin
			st_next.gain_code = auto_gain_value;
		end
		st_next.gain_eighths = mapped_gain;
		// Colour killer state crosses in from the detector domain.
		st_next.col_sync1 = color_detected;
		st_next.col_sync2 = st_reg.col_sync1;
		st_next.color_en = st_reg.mode_reg[COLOR_FORCE_BIT] | st_reg.col_sync2;
		// Sync passes two flops, then a delay line tapped every two clocks.
		st_next.hs_sync1 = {st_reg.hs_sync1[0], hsync_in};
		st_next.hs_sync2 = {st_reg.hs_sync2[0], realtime_src_a};
		st_next.hs_pipe = {st_reg.hs_pipe[5:0], st_reg.hs_sync1[1]};
		st_next.hs_out = hs_taps[LLC_PER_STEP * st_reg.mode_reg[HSYNC_DELAY_LSB +: 2]];
		st_next.rta = st_reg.hs_sync2[1] ^ st_reg.mode_reg[RT_OUT0_INV_BIT];
		st_next.rtb = realtime_src_b ^ st_reg.mode_reg[RT_OUT1_INV_BIT];
	end

	assign hs_taps = {st_reg.hs_pipe, st_reg.hs_sync1[1]};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.gain_reg <= CHROMA_GAIN_CTRL_RESET;
			st_reg.offbw_reg <= CHROMA_OFFSET_BANDWIDTH_RESET;
			st_reg.mode_reg <= MODE_DELAY_CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// The second real-time source is expected on this clock already; it is not resynchronised.
	assign rd_data = st_reg.rd_data;
	assign rd_valid = st_reg.rd_valid;
	assign rd_hit = st_reg.rd_hit;
	assign chroma_gain_manual_sel = st_reg.gain_reg[GAIN_MANUAL_BIT];
	assign chroma_gain_value = st_reg.gain_code;
	assign chroma_gain_eighths = st_reg.gain_eighths;
	assign blue_diff_fine_offset = st_reg.offbw_reg[BLUE_OFFSET_LSB +: 2];
	assign red_diff_fine_offset = st_reg.offbw_reg[RED_OFFSET_LSB +: 2];
	assign blue_offset_quarters = st_reg.offbw_reg[BLUE_OFFSET_LSB +: 2];
	assign red_offset_quarters = st_reg.offbw_reg[RED_OFFSET_LSB +: 2];
	assign chroma_band_wide = st_reg.offbw_reg[BAND_WIDE_BIT];
	assign luma_chroma_band_balance = st_reg.offbw_reg[BAND_BALANCE_LSB +: 3];
	assign color_enable = st_reg.color_en;
	assign horiz_sync_out = st_reg.hs_out;
	assign realtime_out_a = st_reg.rta;
	assign realtime_out_b = st_reg.rtb;
	assign luma_delay_llc2 = sext3(st_reg.mode_reg[LUMA_DELAY_LSB +: 3]);
	assign luma_delay_llc = 5'(sext3(st_reg.mode_reg[LUMA_DELAY_LSB +: 3])) <<< 1;
endmodule // chroma_mode_delay_control_regs

// *** design/chroma_mode_pkg.sv ***
// Purpose: Constants shared by the chroma gain, offset, bandwidth and mode/delay control bank.
// Assumes: Registers are reached by an 8-bit subaddress with byte-wide data from the serial bus.
// Notes: Field positions are given as low bit index only; widths are fixed where the fields are used.
package chroma_mode_pkg;
	localparam logic [7:0] CHROMA_GAIN_CTRL_ADDR = 8'h0F;
	localparam logic [7:0] CHROMA_OFFSET_BANDWIDTH_ADDR = 8'h10;
	localparam logic [7:0] MODE_DELAY_CTRL_ADDR = 8'h11;
	localparam logic [7:0] CHROMA_GAIN_CTRL_RESET = 8'h00;
	localparam logic [7:0] CHROMA_OFFSET_BANDWIDTH_RESET = 8'h00;
	localparam logic [7:0] MODE_DELAY_CTRL_RESET = 8'h00;
	localparam int GAIN_MANUAL_BIT = 7;
	localparam int GAIN_VALUE_LSB = 0;
	localparam int BLUE_OFFSET_LSB = 6;
	localparam int RED_OFFSET_LSB = 4;
	localparam int BAND_WIDE_BIT = 3;
	localparam int BAND_BALANCE_LSB = 0;
	localparam int COLOR_FORCE_BIT = 7;
	localparam int RT_OUT1_INV_BIT = 6;
	localparam int HSYNC_DELAY_LSB = 4;
	localparam int RT_OUT0_INV_BIT = 3;
	localparam int LUMA_DELAY_LSB = 0;
	// Gain in eighths: code 0 is 0.5, code 36 is 1.125, code 127 is 7.5.
	localparam logic [5:0] GAIN_MIN_EIGHTHS = 6'h04;
	localparam logic [7:0] GAIN_NOM_CODE = 8'h24;
	localparam logic [5:0] GAIN_NOM_EIGHTHS = 6'h09;
	localparam logic [5:0] GAIN_MAX_EIGHTHS = 6'h3C;
	localparam int LLC_PER_STEP = 2;
endpackage

// *** design/chroma_gain_map.sv ***
// Purpose: Maps the 7-bit chroma gain code to a gain in eighths.
// Assumes: Piecewise-linear between the three documented points.
// Notes: Purely combinational; registered by the caller.
`timescale 1ns/1ps
module chroma_gain_map (
	input wire logic [6:0] code,
	output logic [5:0] gain_eighths
);
	import chroma_mode_pkg::*;
	logic [15:0] span;
	always_comb begin
		span = 16'h0000;
		if ({1'b0, code} <= GAIN_NOM_CODE) begin
			// Lower segment: 0.5 to 1.125 over codes 0 to 36.
			span = 16'({9'h000, code} * 16'(GAIN_NOM_EIGHTHS - GAIN_MIN_EIGHTHS)) / 16'(GAIN_NOM_CODE);
			gain_eighths = 6'(16'(GAIN_MIN_EIGHTHS) + span);
		end else begin
			// Upper segment: 1.125 to 7.5 over codes 36 to 127.
			span = 16'(16'({9'h000, code} - 16'(GAIN_NOM_CODE))
				* 16'(GAIN_MAX_EIGHTHS - GAIN_NOM_EIGHTHS)) / 16'(8'h7F - GAIN_NOM_CODE);
			gain_eighths = 6'(16'(GAIN_NOM_EIGHTHS) + span);
		end
	end
endmodule // chroma_gain_map

// *** test/host_model.sv ***
// Purpose: Host side of the byte-wide register bus.
// Assumes: Strobes change at the falling clock edge.
// Notes: Released address and data lines are inverted so a stale value is never trusted.
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] sub_addr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	initial begin
		{wr_en, rd_en, sub_addr, wr_data} = 18'h00000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk_sys);
		{wr_en, rd_en, sub_addr, wr_data} = {w, !w, a, d};
		@(negedge clk_sys);
		q = rd_data;
		{wr_en, rd_en, sub_addr, wr_data} = {2'h0, ~a, ~d};
	endtask
endmodule // host_model

// *** test/regs_asserts.sv ***
// Purpose: Port-level checks of the control bank.
// Assumes: One clock, synchronous reset.
// Notes: Gain code lags a write by two cycles.
`timescale 1ns/1ps
module regs_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] sub_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_hit,
	input wire logic [6:0] auto_gain_value,
	input wire logic chroma_gain_manual_sel,
	input wire logic [6:0] chroma_gain_value,
	input wire logic [5:0] chroma_gain_eighths,
	input wire logic [1:0] blue_diff_fine_offset,
	input wire logic [1:0] red_diff_fine_offset,
	input wire logic chroma_band_wide,
	input wire logic [2:0] luma_chroma_band_balance,
	input wire logic signed [4:0] luma_delay_llc
);
	logic [7:0] wd_q, wd_q2;
	always_ff @(posedge clk_sys) {wd_q2, wd_q} <= {wd_q, wr_data};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	read_valid_a: assert property (rd_en |=> rd_valid) else $error("no read valid");
	unmapped_read_a: assert property (rd_en && (sub_addr < 8'h0F || sub_addr > 8'h11)
		|=> rd_data == 8'h00 && !rd_hit) else $error("unmapped read");
	gain_select_a: assert property (wr_en && sub_addr == 8'h0F
		|=> chroma_gain_manual_sel == wd_q[7]) else $error("gain select");
	// The effective gain code is registered once more after the control byte lands.
	gain_prog_a: assert property (wr_en && sub_addr == 8'h0F && wr_data[7] ##1 !wr_en
		|=> ##1 chroma_gain_value == $past(wd_q2[6:0])) else $error("programmed gain");
	gain_auto_a: assert property (!chroma_gain_manual_sel
		|=> chroma_gain_value == $past(auto_gain_value)) else $error("auto gain");
	gain_max_a: assert property (chroma_gain_value == 7'h7F
		|-> chroma_gain_eighths == 6'h3C) else $error("max gain");
	chroma_fields_a: assert property (wr_en && sub_addr == 8'h10
		|=> {blue_diff_fine_offset, red_diff_fine_offset, chroma_band_wide,
		luma_chroma_band_balance} == wd_q) else $error("chroma fields");
	luma_delay_a: assert property (wr_en && sub_addr == 8'h11
		|=> luma_delay_llc == {wd_q[2], wd_q[2:0], 1'h0}) else $error("luma delay");
endmodule // regs_asserts
bind chroma_mode_delay_control_regs regs_asserts chk_i (.*);

// *** test/tb.sv ***
// Purpose: Self-checking bench for the chroma and mode control bank.
// Assumes: The host model drives the bus; the bench drives the video side.
// Notes: Fields are read after a full write and read-back, one and a half cycles after the last gain pipeline stage updates.
`timescale 1ns/1ps
module tb;
	logic clk_sys, sys_rst, wr_en, rd_en, rd_valid, rd_hit, color_detected, hsync_in, color_enable;
	logic realtime_src_a, realtime_src_b, chroma_gain_manual_sel, chroma_band_wide;
	logic horiz_sync_out, realtime_out_a, realtime_out_b;
	logic [7:0] sub_addr, wr_data, rd_data, q;
	logic [6:0] auto_gain_value, chroma_gain_value;
	logic [5:0] chroma_gain_eighths;
	logic [1:0] blue_diff_fine_offset, red_diff_fine_offset, blue_offset_quarters, red_offset_quarters;
	logic [2:0] luma_chroma_band_balance;
	logic signed [3:0] luma_delay_llc2;
	logic signed [4:0] luma_delay_llc;
	localparam logic [7:0] CODES [3] = '{8'h80, 8'hA4, 8'hFF};
	localparam logic [7:0] EIGHTHS [3] = '{8'h04, 8'h09, 8'h3C};
	int mismatches, checks, n;
	chroma_mode_delay_control_regs dut (.*);
	host_model host (.*);
	task automatic chk(input logic [7:0] a, e);
		checks++;
		if (a !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic rw(input logic [7:0] a, d);
		host.xfer(1'h1, a, d, q);
		host.xfer(1'h0, a, 8'h00, q);
		chk(q, d);
	endtask
	task automatic t_reset;
		for (int a = 14; a < 19; a++) begin
			host.xfer(1'h0, 8'(a), 8'h00, q);
			chk(q, 8'h00);
		end
		$display("reset test done");
	endtask
	task automatic t_gain;
		for (int i = 0; i < 3; i++) begin
			rw(8'h0F, CODES[i]);
			chk({1'h0, chroma_gain_value}, {1'h0, CODES[i][6:0]});
			chk({2'h0, chroma_gain_eighths}, EIGHTHS[i]);
		end
		rw(8'h0F, 8'h24);
		chk({1'h0, chroma_gain_value}, 8'h55);
		$display("gain test done");
	endtask
	task automatic t_mode;
		for (int h = 0; h < 4; h++) begin
			realtime_src_b = h[1];
			rw(8'h11, {h[0], h[0], 2'(h), h[0], h[1], 1'h0, h[0]});
			chk({7'h00, color_enable}, {7'h00, h[0]});
			chk({7'h00, realtime_out_a}, {7'h00, !h[0]});
			chk({7'h00, realtime_out_b}, {7'h00, h[1] ^ h[0]});
			chk(8'(luma_delay_llc), 8'(h[1] ? 2 * h[0] - 8 : 2 * h[0]));
			chk(8'(luma_delay_llc2), 8'(h[1] ? h[0] - 4 : h[0]));
			color_detected = 1'h1;
			repeat (4) @(negedge clk_sys);
			chk({7'h00, color_enable}, 8'h01);
			color_detected = 1'h0;
			repeat (4) @(negedge clk_sys);
			chk({7'h00, color_enable}, {7'h00, h[0]});
			hsync_in = 1'h1;
			n = 0;
			while (horiz_sync_out !== 1'h1 && n < 20) begin
				@(negedge clk_sys);
				n++;
			end
			chk(8'(n), 8'(3 + 2 * h));
			hsync_in = 1'h0;
			repeat (12) @(negedge clk_sys);
		end
		$display("mode test done");
	endtask
	task automatic t_chroma;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			d = {2'(i), ~2'(i), i[0], {3{i[1]}}};
			rw(8'h10, d);
			chk({blue_offset_quarters, red_offset_quarters, 4'h0}, {d[7:4], 4'h0});
			chk({blue_diff_fine_offset, red_diff_fine_offset, 4'h0}, {d[7:4], 4'h0});
			chk({4'h0, chroma_band_wide, luma_chroma_band_balance}, {4'h0, d[3:0]});
		end
		$display("chroma test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		{sys_rst, color_detected, hsync_in, realtime_src_a, realtime_src_b} = 5'h12;
		auto_gain_value = 7'h55;
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'h0;
		t_reset;
		t_gain;
		t_mode;
		t_chroma;
		test_done;
	end
	initial begin
		#10000;
		mismatches++;
		test_done;
	end
endmodule // tb
